//--- ipaf_pkg.sv
// constants for the input port and alternate function clock routing block
// =====================================================================
// Functional notes
// - external 16X clock is divided by sixteen to form bit rate
// - external 1X clock is used directly as bit clock
// - reading pin status register returns live unlatched pin levels
// - bit n reads 1 when pin n high, 0 when low
// - pin status reads real level even when pin has alternate use
// - pin 0 is channel A send permit when its mode two bit 4 set
// - pin 1 is channel B send permit when its mode two bit 4 set
// - send permit is active low; low level allows sending
// - pin 2 clocks counter/timer when auxiliary bits 6:4 equal 000
// - pin 2 clocks channel B receiver when its select high nibble E/F
// - pin 3 clocks channel A transmitter when its select low nibble E/F
// - pin 4 clocks channel A receiver when its select high nibble E/F
// - pin 5 clocks channel B transmitter when its select low nibble E/F
// - selectors offer 13 generator rates (codes 0-C), timer output and pin clocks
// - timer output source is treated as 16X and divided by sixteen
`default_nettype none
package ipaf_pkg;
   // =================================================================
   // register map
   localparam logic [3:0] ADDR_PIN_LEVELS  = 4'h0;
   localparam logic [3:0] ADDR_MODE_TWO_A  = 4'h1;
   localparam logic [3:0] ADDR_MODE_TWO_B  = 4'h2;
   localparam logic [3:0] ADDR_AUX_CTRL    = 4'h3;
   localparam logic [3:0] ADDR_CLK_SEL_A   = 4'h4;
   localparam logic [3:0] ADDR_CLK_SEL_B   = 4'h5;
   // =================================================================
   // fields and values
   localparam int         PIN_COUNT        = 6;
   localparam int         SEND_PERMIT_BIT  = 4;
   localparam int         TIMER_SRC_LSB    = 4;
   localparam logic [2:0] TIMER_SRC_PIN    = 3'h0;
   localparam logic [3:0] SEL_EXT_16X      = 4'hE;
   localparam logic [3:0] SEL_EXT_1X       = 4'hF;
   localparam logic [3:0] SEL_TIMER        = 4'hD;
   localparam logic [4:0] GEN_RATE_COUNT   = 5'h17;
   localparam logic [3:0] DIV_16_LAST      = 4'hF;
   localparam logic [7:0] REG_RESET        = 8'h00;
endpackage : ipaf_pkg
`default_nettype wire

//--- ipaf_top.sv
// input port with alternate function clock and send permit routing
//
// Implementation choices: strobed register access and the address map.
`default_nettype none
module ipaf_top (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // input pins
   input  wire logic [5:0]  in_pins,
   // internal clock sources
   input  wire logic [22:0] gen_rate_tick,
   input  wire logic        timer_out_tick,
   // routed functions
   output logic             chan_a_send_ok,
   output logic             chan_b_send_ok,
   output logic             timer_ext_clock,
   output logic             chan_a_tx_bit_tick,
   output logic             chan_a_rx_bit_tick,
   output logic             chan_b_tx_bit_tick,
   output logic             chan_b_rx_bit_tick,
   output logic             chan_a_tx_samp_tick,
   output logic             chan_a_rx_samp_tick,
   output logic             chan_b_tx_samp_tick,
   output logic             chan_b_rx_samp_tick
);
   // =================================================================
   // state
   typedef struct packed {
      logic [5:0] sync1;
      logic [5:0] sync2;
      logic [5:0] prev;
      logic [7:0] mode_two_a;
      logic [7:0] mode_two_b;
      logic [7:0] aux_ctrl;
      logic [7:0] clk_sel_a;
      logic [7:0] clk_sel_b;
      logic [15:0] div_cnt;
      logic [3:0] bit_tick;
      logic [3:0] samp_tick;
      logic       timer_clk;
      logic       send_a;
      logic       send_b;
      logic [7:0] rdata;
   } ipaf_state_t;

   ipaf_state_t s_q;
   ipaf_state_t s_d;
   logic [5:0]  rise;
   logic [3:0]  sel_code [4];
   logic [3:0]  ext_rise;

   // =================================================================
   // channel clock selection: 0 tx a, 1 rx a, 2 tx b, 3 rx b
   assign rise = s_q.sync2 & ~s_q.prev;
   assign sel_code[0] = s_q.clk_sel_a[3:0];
   assign sel_code[1] = s_q.clk_sel_a[7:4];
   assign sel_code[2] = s_q.clk_sel_b[3:0];
   assign sel_code[3] = s_q.clk_sel_b[7:4];
   assign ext_rise[0] = rise[3];
   assign ext_rise[1] = rise[4];
   assign ext_rise[2] = rise[5];
   assign ext_rise[3] = rise[2];

   always_comb
   begin
      s_d       = s_q;
      s_d.sync1 = in_pins;
      s_d.sync2 = s_q.sync1;
      s_d.prev  = s_q.sync2;
      s_d.rdata = 8'h00;
      // register port
      if (reg_wr)
      begin
         case (reg_addr)
            ipaf_pkg::ADDR_MODE_TWO_A: s_d.mode_two_a = reg_wdata;
            ipaf_pkg::ADDR_MODE_TWO_B: s_d.mode_two_b = reg_wdata;
            ipaf_pkg::ADDR_AUX_CTRL:   s_d.aux_ctrl   = reg_wdata;
            ipaf_pkg::ADDR_CLK_SEL_A:  s_d.clk_sel_a  = reg_wdata;
            ipaf_pkg::ADDR_CLK_SEL_B:  s_d.clk_sel_b  = reg_wdata;
            default: ;
         endcase
      end
      if (reg_rd)
      begin
         case (reg_addr)
            ipaf_pkg::ADDR_PIN_LEVELS:
               s_d.rdata = {2'h0, s_q.sync2};
            ipaf_pkg::ADDR_MODE_TWO_A: s_d.rdata = s_q.mode_two_a;
            ipaf_pkg::ADDR_MODE_TWO_B: s_d.rdata = s_q.mode_two_b;
            ipaf_pkg::ADDR_AUX_CTRL:   s_d.rdata = s_q.aux_ctrl;
            ipaf_pkg::ADDR_CLK_SEL_A:  s_d.rdata = s_q.clk_sel_a;
            ipaf_pkg::ADDR_CLK_SEL_B:  s_d.rdata = s_q.clk_sel_b;
            default:                   s_d.rdata = 8'h00;
         endcase
      end
      // send permit, active low pin; permitted when function off
      s_d.send_a = !s_q.mode_two_a[ipaf_pkg::SEND_PERMIT_BIT]
                   || !s_q.sync2[0];
      s_d.send_b = !s_q.mode_two_b[ipaf_pkg::SEND_PERMIT_BIT]
                   || !s_q.sync2[1];
      // counter/timer external clock
      s_d.timer_clk = (s_q.aux_ctrl[ipaf_pkg::TIMER_SRC_LSB +: 3]
                       == ipaf_pkg::TIMER_SRC_PIN) && rise[2];
      // per direction clock
      for (int i = 0; i < 4; i++)
      begin
         logic samp;
         logic div_en;
         samp   = 1'b0;
         div_en = 1'b0;
         s_d.bit_tick[i] = 1'b0;
         if (sel_code[i] == ipaf_pkg::SEL_EXT_1X)
            s_d.bit_tick[i] = ext_rise[i];
         else if (sel_code[i] == ipaf_pkg::SEL_EXT_16X)
         begin
            samp   = ext_rise[i];
            div_en = 1'b1;
         end
         else if (sel_code[i] == ipaf_pkg::SEL_TIMER)
         begin
            samp   = timer_out_tick;
            div_en = 1'b1;
         end
         else if ({1'b0, sel_code[i]} < ipaf_pkg::GEN_RATE_COUNT)
         begin
            samp   = gen_rate_tick[sel_code[i]];
            div_en = 1'b1;
         end
         s_d.samp_tick[i] = samp;
         if (!div_en)
            s_d.div_cnt[4*i +: 4] = 4'h0;
         else if (samp)
         begin
            s_d.div_cnt[4*i +: 4] = s_q.div_cnt[4*i +: 4] + 4'h1;
            s_d.bit_tick[i] = (s_q.div_cnt[4*i +: 4]
                               == ipaf_pkg::DIV_16_LAST);
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         s_q <= '0;
         s_q.mode_two_a <= ipaf_pkg::REG_RESET;
         s_q.mode_two_b <= ipaf_pkg::REG_RESET;
         s_q.aux_ctrl   <= ipaf_pkg::REG_RESET;
         s_q.clk_sel_a  <= ipaf_pkg::REG_RESET;
         s_q.clk_sel_b  <= ipaf_pkg::REG_RESET;
         s_q.send_a <= 1'b1;
         s_q.send_b <= 1'b1;
      end
      else
         s_q <= s_d;
   end

   // =================================================================
   // outputs
   assign reg_rdata           = s_q.rdata;
   assign chan_a_send_ok      = s_q.send_a;
   assign chan_b_send_ok      = s_q.send_b;
   assign timer_ext_clock     = s_q.timer_clk;
   assign chan_a_tx_bit_tick  = s_q.bit_tick[0];
   assign chan_a_rx_bit_tick  = s_q.bit_tick[1];
   assign chan_b_tx_bit_tick  = s_q.bit_tick[2];
   assign chan_b_rx_bit_tick  = s_q.bit_tick[3];
   assign chan_a_tx_samp_tick = s_q.samp_tick[0];
   assign chan_a_rx_samp_tick = s_q.samp_tick[1];
   assign chan_b_tx_samp_tick = s_q.samp_tick[2];
   assign chan_b_rx_samp_tick = s_q.samp_tick[3];
endmodule : ipaf_top
`default_nettype wire

//--- ipaf_top_props.sv
// assertions on the input port routing block
`default_nettype none
module ipaf_top_props (
   // watched ports
   input wire logic       ref_clk,
   input wire logic       reset,
   input wire logic [3:0] reg_addr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [5:0] in_pins,
   input wire logic       chan_a_send_ok,
   input wire logic       chan_b_send_ok,
   input wire logic       timer_ext_clock,
   input wire logic       chan_a_tx_bit_tick,
   input wire logic       chan_a_tx_samp_tick,
   input wire logic       chan_a_rx_bit_tick,
   input wire logic       chan_a_rx_samp_tick,
   input wire logic       chan_b_rx_bit_tick,
   input wire logic       chan_b_rx_samp_tick
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   // =========================
   // sample pulses since last bit tick
   logic [4:0] nsamp_q;
   always_ff @(posedge ref_clk)
      nsamp_q <= (reset || chan_a_rx_bit_tick) ? 5'h00
         : nsamp_q + {4'h0, chan_a_rx_samp_tick};
   sequence s_rose(p);
      $past(p, 3) && !$past(p, 4);
   endsequence
   property p_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("rdata not idle");
   property p_pins; ($stable(in_pins))[*4] ##0 (reg_rd && reg_addr == 4'h0)
      |=> reg_rdata == {2'h0, $past(in_pins)}; endproperty
   a_pins: assert property (p_pins) else $error("pin read");
   property p_permit_a; (!in_pins[0])[*4] |-> chan_a_send_ok; endproperty
   a_permit_a: assert property (p_permit_a) else $error("permit a");
   property p_permit_b; (!in_pins[1])[*4] |-> chan_b_send_ok; endproperty
   a_permit_b: assert property (p_permit_b) else $error("permit b");
   property p_timer; timer_ext_clock |-> s_rose(in_pins[2]); endproperty
   a_timer: assert property (p_timer) else $error("timer clock");
   property p_tx_1x; chan_a_tx_bit_tick && !chan_a_tx_samp_tick
      && !$past(chan_a_tx_samp_tick) |-> s_rose(in_pins[3]); endproperty
   a_tx_1x: assert property (p_tx_1x) else $error("a tx 1x");
   property p_rx_1x; chan_b_rx_bit_tick && !chan_b_rx_samp_tick
      && !$past(chan_b_rx_samp_tick) |-> s_rose(in_pins[2]); endproperty
   a_rx_1x: assert property (p_rx_1x) else $error("b rx 1x");
   property p_div16; chan_a_rx_bit_tick && (chan_a_rx_samp_tick ||
      $past(chan_a_rx_samp_tick)) |-> nsamp_q inside {5'h0F, 5'h10};
   endproperty
   a_div16: assert property (p_div16) else $error("divide by 16");
endmodule : ipaf_top_props
bind ipaf_top ipaf_top_props u_props (.ref_clk, .reset, .reg_addr, .reg_rd,
   .reg_rdata, .in_pins, .chan_a_send_ok, .chan_b_send_ok, .timer_ext_clock,
   .chan_a_tx_bit_tick, .chan_a_tx_samp_tick, .chan_a_rx_bit_tick,
   .chan_a_rx_samp_tick, .chan_b_rx_bit_tick, .chan_b_rx_samp_tick);
`default_nettype wire

//--- ipaf_pin_src.sv
// model of the pin side: modem lines and external clocks
`default_nettype none
module ipaf_pin_src (
   // clock and control
   input  wire logic       ref_clk,
   input  wire logic [5:0] run,
   input  wire logic [5:0] lvl,
   // pins
   output logic      [5:0] in_pins
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] ph_q = 4'h0;
   always @(posedge ref_clk)
      ph_q <= ph_q + 4'h1;
   // clocks toggle every 8 cycles; pins not in run follow lvl
   assign in_pins = (run & {6{ph_q[3]}}) | (~run & lvl);
endmodule : ipaf_pin_src
`default_nettype wire

//--- ipaf_top_bench.sv
// self-checking bench for the input port routing block
`default_nettype none
module ipaf_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata;
   logic [5:0] in_pins, run = 6'h00, lvl = 6'h00;
   wire logic [10:0] outs;
   logic [2:0] g_q = 3'h0;
   int failures = 0, num_checks = 0;
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) g_q <= g_q + 3'h1;
   ipaf_pin_src u_src (.ref_clk, .run, .lvl, .in_pins);
   ipaf_top dut (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .in_pins, .gen_rate_tick({22'h0, g_q[1:0] == 2'h0}),
      .timer_out_tick(g_q == 3'h0), .chan_a_send_ok(outs[10]),
      .chan_b_send_ok(outs[9]), .timer_ext_clock(outs[8]),
      .chan_a_tx_bit_tick(outs[7]), .chan_a_rx_bit_tick(outs[6]),
      .chan_b_tx_bit_tick(outs[5]), .chan_b_rx_bit_tick(outs[4]),
      .chan_a_tx_samp_tick(outs[3]), .chan_a_rx_samp_tick(outs[2]),
      .chan_b_tx_samp_tick(outs[1]), .chan_b_rx_samp_tick(outs[0]));
   // =========================
   // shared tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      chk(reg_rdata, exp);
   endtask : rd
   task automatic settle(input logic [5:0] v);
      @(posedge ref_clk);
      lvl <= v;
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask : settle
   task automatic meas(input logic [7:0] ca, cb, aux, input logic [71:0] e);
      logic [7:0] n [9] = '{default: 8'h00};
      wr(ipaf_pkg::ADDR_CLK_SEL_A, ca);
      wr(ipaf_pkg::ADDR_CLK_SEL_B, cb);
      wr(ipaf_pkg::ADDR_AUX_CTRL, aux);
      repeat (300) @(posedge ref_clk);
      repeat (512)
      begin
         @(negedge ref_clk);
         for (int i = 0; i < 9; i++) n[i] += {7'h0, outs[i]};
      end
      for (int i = 0; i < 9; i++) chk(n[i], e[8*i +: 8]);
   endtask : meas
   task automatic test_done;
      if (failures == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done
   // =========================
   // scenarios
   task automatic t_pins;
      logic [5:0] pat [4] = '{6'h2A, 6'h15, 6'h3F, 6'h00};
      for (int i = 0; i < 4; i++)
      begin
         settle(pat[i]);
         rd(ipaf_pkg::ADDR_PIN_LEVELS, {2'h0, pat[i]});
      end
      wr(ipaf_pkg::ADDR_PIN_LEVELS, 8'hFF);
      rd(ipaf_pkg::ADDR_PIN_LEVELS, 8'h00);
      rd(4'hF, 8'h00);
   endtask : t_pins
   task automatic t_permit;
      wr(ipaf_pkg::ADDR_MODE_TWO_A, 8'h10);
      settle(6'h03);
      chk({6'h0, outs[10:9]}, 8'h01);
      rd(ipaf_pkg::ADDR_PIN_LEVELS, 8'h03);
      settle(6'h02);
      chk({6'h0, outs[10:9]}, 8'h03);
      wr(ipaf_pkg::ADDR_MODE_TWO_A, 8'h00);
      wr(ipaf_pkg::ADDR_MODE_TWO_B, 8'h10);
      settle(6'h02);
      chk({6'h0, outs[10:9]}, 8'h02);
      settle(6'h00);
      chk({6'h0, outs[10:9]}, 8'h03);
   endtask : t_permit
   task automatic t_clocks;
      @(posedge ref_clk);
      run <= 6'h3C;
      meas(8'hFF, 8'hEE, 8'h00,
         72'h20_20_20_02_02_00_00_20_20);
      meas(8'hDD, 8'h10, 8'h60, 72'h00_04_04_08_00_40_40_80_00);
      meas(8'hEF, 8'hFE, 8'h10,
         72'h00_20_02_02_20_00_20_20_00);
   endtask : t_clocks
   initial
   begin
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      t_pins();
      t_permit();
      t_clocks();
      test_done();
   end
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      test_done();
   end
endmodule : ipaf_top_bench
`default_nettype wire
